//--- src/otd_defines.vh
// otd_defines.vh: register offsets, field layouts, reset values and codes
// for the overtravel and direction logic; included by every design file
`ifndef OTD_DEFINES_VH
`define OTD_DEFINES_VH

// register byte offsets
`define OTD_REG_CFG 4'h0
`define OTD_REG_STAT 4'h4
`define OTD_REG_IRQ_STAT 4'h8
`define OTD_REG_IRQ_MASK 4'hC

// cfg field positions
`define OTD_CFG_DIR_BIT 0
`define OTD_CFG_TORQUE_BIT 1
`define OTD_CFG_STOPMODE_LSB 4
`define OTD_CFG_FWDMAP_LSB 8
`define OTD_CFG_REVMAP_LSB 12
`define OTD_CFG_ESTOP_LSB 16

// cfg reset values
`define OTD_DIR_RESET 1'b0
`define OTD_STOPMODE_RESET 2'h0
`define OTD_MAP_RESET 4'h8
`define OTD_ESTOP_RESET 10'h320

// mapping codes
`define OTD_FWDMAP_TERM 4'h2
`define OTD_REVMAP_TERM 4'h3
`define OTD_MAP_UNUSED 4'h8
`define OTD_FWDMAP_INV 4'hB
`define OTD_REVMAP_INV 4'hC

// overtravel stop modes
`define OTD_STOP_SERVO_OFF 2'h0
`define OTD_STOP_DECEL_CLAMP 2'h1
`define OTD_STOP_DECEL_COAST 2'h2

// motor action codes
`define OTD_ACT_RUN 2'h0
`define OTD_ACT_COAST 2'h1
`define OTD_ACT_DECEL 2'h2
`define OTD_ACT_CLAMP 2'h3

// interrupt status bits
`define OTD_IRQ_FWD_BIT 0
`define OTD_IRQ_REV_BIT 1
`define OTD_IRQ_STOP_BIT 2

`endif

//--- src/otd_limit_chan.v
// otd_limit_chan.v: one limit channel, two-flop synchroniser then mapping
// assumes the terminal is asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
`include "otd_defines.vh"
module otd_limit_chan #(
  parameter [3:0] TERM_CODE = 4'h2,
  parameter [3:0] INV_CODE = 4'hB
) (
  input wire aclk,
  input wire aresetn,
  input wire terminal,
  input wire [3:0] mapping,
  output reg limit_active
);
  reg meta_q;
  reg sync_q;

  // open terminal reads high; high means blocked
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= terminal;
      sync_q <= meta_q;
    end
  end

  always @*
  begin
    case (mapping)
      TERM_CODE: limit_active = sync_q;
      INV_CODE: limit_active = ~sync_q;
      default: limit_active = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- src/otd_stop_fsm.v
// otd_stop_fsm.v: overtravel stop sequencer for one blocked direction
// assumes motor_stopped comes from the speed loop, synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
`include "otd_defines.vh"
module otd_stop_fsm (
  input wire aclk,
  input wire aresetn,
  input wire trip,
  input wire [1:0] stop_mode,
  input wire torque_mode,
  input wire motor_stopped,
  output reg [1:0] action
);
  localparam [1:0] S_RUN = 2'd0;
  localparam [1:0] S_DECEL = 2'd1;
  localparam [1:0] S_HOLD = 2'd2;
  reg [1:0] state_q;
  reg [1:0] state_d;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RUN:
        if (trip)
          state_d = (stop_mode == `OTD_STOP_SERVO_OFF) ? S_HOLD : S_DECEL;
      S_DECEL:
        if (!trip)
          state_d = S_RUN;
        else if (motor_stopped)
          state_d = S_HOLD;
      S_HOLD:
        if (!trip)
          state_d = S_RUN;
      default:
        state_d = S_RUN;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= S_RUN;
    else
      state_q <= state_d;
  end

  always @*
  begin
    case (state_q)
      S_DECEL:
        action = `OTD_ACT_DECEL;
      S_HOLD:
        if (torque_mode || stop_mode != `OTD_STOP_DECEL_CLAMP)
          action = `OTD_ACT_COAST;
        else
          action = `OTD_ACT_CLAMP;
      default:
        action = `OTD_ACT_RUN;
    endcase
  end
endmodule
`default_nettype wire

//--- src/otd_top.v
// otd_top.v: direction select and overtravel limit logic with axi4-lite regs
// assumes limit terminals are driven by normally closed switches to 0V
//
// Notes on behaviour
// - direction select 0 (default) means forward is ccw, 1 means cw.
// - reversed direction flips only shaft motion sign, nothing else.
// - an active limit forces the motor to stop.
// - forward terminal low permits forward; high blocks forward, reverse stays allowed.
// - reverse terminal low permits reverse; high blocks reverse, forward stays allowed.
// - forward mapping 2 uses the terminal; open blocks, 0V releases.
// - forward mapping 8 (default) ignores the terminal, forward always allowed.
// - forward mapping B uses the terminal with inverted sense.
// - reverse mapping 3 uses the terminal; open blocks, 0V releases.
// - reverse mapping 8 (default) ignores the terminal, reverse always allowed.
// - reverse mapping C uses the terminal with inverted sense.
// - stop mode 0 servo-off, 1 decel then zero clamp, 2 decel then coast.
// - in torque control the motor coasts after an overtravel stop.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "otd_defines.vh"
module otd_top (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire forward_limit_input,
  input wire reverse_limit_input,
  input wire cmd_forward,
  input wire cmd_reverse,
  input wire motor_stopped,
  output reg shaft_positive,
  output reg shaft_negative,
  output reg [1:0] motor_action,
  output reg [9:0] stop_torque,
  output reg irq
);
  reg dir_q;
  reg torque_q;
  reg [1:0] stop_mode_q;
  reg [3:0] fwd_map_q;
  reg [3:0] rev_map_q;
  reg [9:0] estop_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [3:0] aw_q;
  reg aw_have_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  reg w_have_q;
  reg fwd_prev_q;
  reg rev_prev_q;
  reg stop_prev_q;
  wire fwd_lim;
  wire rev_lim;
  wire [1:0] fwd_act;
  wire [1:0] rev_act;
  wire fwd_trip;
  wire rev_trip;
  wire do_write;
  wire [2:0] events;
  wire [2:0] w1c;
  reg [31:0] cfg_word;
  reg [31:0] rd_word;
  reg [1:0] act_d;

  otd_limit_chan #(
    .TERM_CODE(`OTD_FWDMAP_TERM),
    .INV_CODE(`OTD_FWDMAP_INV)
  ) u_fwd (
    .aclk(aclk),
    .aresetn(aresetn),
    .terminal(forward_limit_input),
    .mapping(fwd_map_q),
    .limit_active(fwd_lim)
  );

  otd_limit_chan #(
    .TERM_CODE(`OTD_REVMAP_TERM),
    .INV_CODE(`OTD_REVMAP_INV)
  ) u_rev (
    .aclk(aclk),
    .aresetn(aresetn),
    .terminal(reverse_limit_input),
    .mapping(rev_map_q),
    .limit_active(rev_lim)
  );

  // a limit trips only while motion into it is commanded
  assign fwd_trip = fwd_lim & cmd_forward;
  assign rev_trip = rev_lim & cmd_reverse;

  otd_stop_fsm u_fwd_stop (
    .aclk(aclk),
    .aresetn(aresetn),
    .trip(fwd_trip),
    .stop_mode(stop_mode_q),
    .torque_mode(torque_q),
    .motor_stopped(motor_stopped),
    .action(fwd_act)
  );

  otd_stop_fsm u_rev_stop (
    .aclk(aclk),
    .aresetn(aresetn),
    .trip(rev_trip),
    .stop_mode(stop_mode_q),
    .torque_mode(torque_q),
    .motor_stopped(motor_stopped),
    .action(rev_act)
  );

  always @*
  begin
    if (fwd_act != `OTD_ACT_RUN)
    begin
      act_d = fwd_act;
    end
    else
    begin
      act_d = rev_act;
    end
  end

  // motion outputs and stop action
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shaft_positive <= 1'b0;
      shaft_negative <= 1'b0;
      motor_action <= `OTD_ACT_RUN;
      stop_torque <= `OTD_ESTOP_RESET;
    end
    else
    begin
      // permitted direction, then mapped to shaft sign
      shaft_positive <= dir_q ? (cmd_reverse & ~rev_lim) : (cmd_forward & ~fwd_lim);
      shaft_negative <= dir_q ? (cmd_forward & ~fwd_lim) : (cmd_reverse & ~rev_lim);
      motor_action <= act_d;
      stop_torque <= estop_q;
    end
  end

  // events: new limit and new stop
  assign events = {(act_d != `OTD_ACT_RUN) & ~stop_prev_q, rev_lim & ~rev_prev_q, fwd_lim & ~fwd_prev_q};

  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign w1c = (do_write && aw_q == `OTD_REG_IRQ_STAT && ws_q[0]) ? w_q[2:0] : 3'h0;

  always @*
  begin
    cfg_word = 32'h0;
    cfg_word[`OTD_CFG_DIR_BIT] = dir_q;
    cfg_word[`OTD_CFG_TORQUE_BIT] = torque_q;
    cfg_word[`OTD_CFG_STOPMODE_LSB +: 2] = stop_mode_q;
    cfg_word[`OTD_CFG_FWDMAP_LSB +: 4] = fwd_map_q;
    cfg_word[`OTD_CFG_REVMAP_LSB +: 4] = rev_map_q;
    cfg_word[`OTD_CFG_ESTOP_LSB +: 10] = estop_q;
    case (s_axi_araddr)
      `OTD_REG_CFG: rd_word = cfg_word;
      `OTD_REG_STAT: rd_word = {26'h0, act_d, shaft_negative, shaft_positive, rev_lim, fwd_lim};
      `OTD_REG_IRQ_STAT: rd_word = {29'h0, irq_stat_q};
      `OTD_REG_IRQ_MASK: rd_word = {29'h0, irq_mask_q};
      default: rd_word = 32'h0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      w_have_q <= 1'b0;
      dir_q <= `OTD_DIR_RESET;
      torque_q <= 1'b0;
      stop_mode_q <= `OTD_STOPMODE_RESET;
      fwd_map_q <= `OTD_MAP_RESET;
      rev_map_q <= `OTD_MAP_RESET;
      estop_q <= `OTD_ESTOP_RESET;
      irq_mask_q <= 3'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= {s_axi_awaddr[3:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_q == `OTD_REG_CFG)
        begin
          if (ws_q[0])
          begin
            dir_q <= w_q[`OTD_CFG_DIR_BIT];
            torque_q <= w_q[`OTD_CFG_TORQUE_BIT];
            stop_mode_q <= w_q[`OTD_CFG_STOPMODE_LSB +: 2];
          end
          if (ws_q[1])
          begin
            fwd_map_q <= w_q[`OTD_CFG_FWDMAP_LSB +: 4];
            rev_map_q <= w_q[`OTD_CFG_REVMAP_LSB +: 4];
          end
          if (ws_q[2])
          begin
            estop_q[7:0] <= w_q[`OTD_CFG_ESTOP_LSB +: 8];
          end
          if (ws_q[3])
          begin
            estop_q[9:8] <= w_q[`OTD_CFG_ESTOP_LSB + 8 +: 2];
          end
        end
        if (aw_q == `OTD_REG_IRQ_MASK && ws_q[0])
          irq_mask_q <= w_q[2:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: address taken, then data held until rready
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= 2'h0;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky status, edge detectors and level interrupt
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= 3'h0;
      fwd_prev_q <= 1'b0;
      rev_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      // set wins over write-one-clear
      irq_stat_q <= (irq_stat_q & ~w1c) | events;
      fwd_prev_q <= fwd_lim;
      rev_prev_q <= rev_lim;
      stop_prev_q <= (act_d != `OTD_ACT_RUN);
      irq <= |(((irq_stat_q & ~w1c) | events) & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

//--- testbench/otd_nc_switch.sv
// otd_nc_switch.sv: two normally closed limit switches to 0v with pull-ups
// assumes the bench says when the axis sits on each switch
`timescale 1ns/1ps
`default_nettype none
module otd_nc_switch (
  input wire logic fwd_hit,
  input wire logic rev_hit,
  output wire logic fwd_term,
  output wire logic rev_term
);
  // closed switch holds 0v, an actuated switch opens and the pull-up wins
  assign fwd_term = fwd_hit ? 1'b1 : 1'b0;
  assign rev_term = rev_hit ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

//--- testbench/otd_chk_sva.sv
// otd_chk_sva.sv: port assertions for otd_top
// assumes cfg writes bring aw and w together with all strobes set
`timescale 1ns/1ps
`default_nettype none
`include "otd_defines.vh"
module otd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic cmd_forward,
  input wire logic cmd_reverse,
  input wire logic shaft_positive,
  input wire logic shaft_negative,
  input wire logic [1:0] motor_action,
  input wire logic [9:0] stop_torque
);
  reg [31:0] cfg_q;
  reg [31:0] cfg_p;
  reg [31:0] cfg_pp;
  wire [3:0] fm = cfg_q[11:8];
  wire [3:0] rm = cfg_q[15:12];
  wire sf = cfg_pp[0] ? shaft_negative : shaft_positive;
  wire sr = cfg_pp[0] ? shaft_positive : shaft_negative;
  wire fo = cmd_forward & ~cmd_reverse;
  wire ro = cmd_reverse & ~cmd_forward;
  wire ft = fm == `OTD_FWDMAP_TERM && forward_limit_input && fo;
  wire cs = cfg_q == cfg_p;
  always @(posedge aclk)
  begin
    cfg_p <= cfg_q;
    cfg_pp <= cfg_p;
    if (!aresetn)
      cfg_q <= 32'h03208800;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `OTD_REG_CFG)
      cfg_q <= s_axi_wdata;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_fwd_open;
    (fm == `OTD_FWDMAP_TERM && forward_limit_input)[*5] |-> !sf;
  endproperty
  a_fwd_open: assert property (p_fwd_open) else $error("forward drive with open terminal");
  property p_fwd_ign;
    (fm == `OTD_MAP_UNUSED && fo)[*5] |-> sf;
  endproperty
  a_fwd_ign: assert property (p_fwd_ign) else $error("forward drive missing");
  property p_fwd_inv;
    (fm == `OTD_FWDMAP_INV && !forward_limit_input)[*5] |-> !sf;
  endproperty
  a_fwd_inv: assert property (p_fwd_inv) else $error("inverted forward limit ignored");
  property p_rev_open;
    (rm == `OTD_REVMAP_TERM && reverse_limit_input)[*5] |-> !sr;
  endproperty
  a_rev_open: assert property (p_rev_open) else $error("reverse drive with open terminal");
  property p_rev_ign;
    (rm == `OTD_MAP_UNUSED && ro)[*5] |-> sr;
  endproperty
  a_rev_ign: assert property (p_rev_ign) else $error("reverse drive missing");
  property p_rev_inv;
    (rm == `OTD_REVMAP_INV && !reverse_limit_input)[*5] |-> !sr;
  endproperty
  a_rev_inv: assert property (p_rev_inv) else $error("inverted reverse limit ignored");
  property p_sync;
    (fm == `OTD_FWDMAP_TERM && fo && !forward_limit_input)[*5] ##1 ft ##1 ft |=> sf;
  endproperty
  a_sync: assert property (p_sync) else $error("limit reached shaft unsynchronised");
  property p_estop;
    cs[*2] |-> stop_torque == cfg_q[25:16];
  endproperty
  a_estop: assert property (p_estop) else $error("stop torque differs from config");
  property p_servo_off;
    (!ft)[*3] ##1 (ft && cfg_q[5:4] == `OTD_STOP_SERVO_OFF)[*6] |-> motor_action == `OTD_ACT_COAST;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("no coast on overtravel");
  property p_torque_coast;
    cfg_q[1] [*3] |-> motor_action != `OTD_ACT_CLAMP;
  endproperty
  a_torque_coast: assert property (p_torque_coast) else $error("clamp in torque control");
endmodule
bind otd_top otd_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .forward_limit_input, .reverse_limit_input, .cmd_forward, .cmd_reverse,
  .shaft_positive, .shaft_negative, .motor_action, .stop_torque);
`default_nettype wire

//--- testbench/otd_top_tb.sv
// otd_top_tb.sv: random and corner tests of otd_top
// assumes otd_chk is bound and otd_nc_switch drives the terminals
`timescale 1ns/1ps
`default_nettype none
`include "otd_defines.vh"
module otd_top_tb;
  logic aclk = 0, aresetn = 0, fwd_hit, rev_hit, cmd_forward, cmd_reverse, motor_stopped;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, shaft_positive, shaft_negative, irq;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h451F, cfg, d, e;
  logic [1:0] s_axi_bresp, s_axi_rresp, motor_action;
  logic [9:0] stop_torque;
  wire forward_limit_input, reverse_limit_input;
  logic [3:0] fmt [3] = '{`OTD_FWDMAP_TERM, `OTD_MAP_UNUSED, `OTD_FWDMAP_INV};
  logic [3:0] rmt [3] = '{`OTD_REVMAP_TERM, `OTD_MAP_UNUSED, `OTD_REVMAP_INV};
  integer error_cnt = 0, n_tests = 0, cyc = 0, i, m;
  always #20 aclk = ~aclk;
  otd_nc_switch sw (.fwd_hit, .rev_hit, .fwd_term(forward_limit_input), .rev_term(reverse_limit_input));
  otd_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forward_limit_input,
    .reverse_limit_input, .cmd_forward, .cmd_reverse, .motor_stopped, .shaft_positive, .shaft_negative,
    .motor_action, .stop_torque, .irq);
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [1:0] exp_shaft(input [31:0] c, input fl, input rl, input cf, input cr);
    logic pf, pr;
    begin
      pf = cf & (c[11:8] == `OTD_FWDMAP_TERM ? !fl : c[11:8] == `OTD_FWDMAP_INV ? fl : 1'b1);
      pr = cr & (c[15:12] == `OTD_REVMAP_TERM ? !rl : c[15:12] == `OTD_REVMAP_INV ? rl : 1'b1);
      exp_shaft = c[0] ? {pf, pr} : {pr, pf};
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task rst;
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      {fwd_hit, rev_hit, cmd_forward, cmd_reverse, motor_stopped} <= 5'h00;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, 2'h0);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk(s_axi_rresp, 2'h0);
      s_axi_rready <= 1'b0;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      complete_run;
    end
  end
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    {fwd_hit, rev_hit, cmd_forward, cmd_reverse, motor_stopped} = 5'h00;
    rst;
    rd(`OTD_REG_CFG);
    chk(d, {6'h00, `OTD_ESTOP_RESET, `OTD_MAP_RESET, `OTD_MAP_RESET, 4'h0, 3'h0, `OTD_DIR_RESET});
    chk(stop_torque, `OTD_ESTOP_RESET);
    rd(`OTD_REG_IRQ_MASK);
    chk(d, 32'h0);
    $display("test reset values done");
    for (i = 0; i < 40; i++)
    begin
      d = rnd();
      cfg = {6'h00, d[25:16], rmt[d[13:12] % 3], fmt[d[9:8] % 3], 2'h0, (d[4] ? 2'h1 : {d[5], 1'b0}), 2'h0, d[1:0]};
      wr(`OTD_REG_CFG, cfg);
      e = rnd();
      fwd_hit <= e[0];
      rev_hit <= e[1];
      cmd_forward <= e[2] & ~e[3];
      cmd_reverse <= e[3];
      repeat (6) @(posedge aclk);
      chk({shaft_negative, shaft_positive}, exp_shaft(cfg, e[0], e[1], e[2] & ~e[3], e[3]));
      chk(stop_torque, cfg[25:16]);
      rd(`OTD_REG_CFG);
      chk(d, cfg);
    end
    $display("test random mapping done");
    for (m = 0; m < 4; m++)
    begin
      rst;
      wr(`OTD_REG_IRQ_MASK, m == 2 ? 32'h0 : 32'h7);
      cmd_forward <= 1'b1;
      wr(`OTD_REG_CFG, {16'h0320, `OTD_MAP_RESET, `OTD_FWDMAP_TERM, 2'h0, (m == 3 ? 2'h1 : 2'(m)), 2'h0, m == 3, 1'b0});
      repeat (4) @(posedge aclk);
      chk(shaft_positive, 1'b1);
      fwd_hit <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(motor_action, m == 0 ? `OTD_ACT_COAST : `OTD_ACT_DECEL);
      chk(shaft_positive, 1'b0);
      motor_stopped <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(motor_action, m == 1 ? `OTD_ACT_CLAMP : `OTD_ACT_COAST);
      rd(`OTD_REG_STAT);
      chk(d, {26'h0, (m == 1 ? `OTD_ACT_CLAMP : `OTD_ACT_COAST), 4'h1});
      chk(irq, m != 2);
      rd(`OTD_REG_IRQ_STAT);
      chk(d, 32'h5);
      wr(`OTD_REG_IRQ_STAT, 32'h7);
      rd(`OTD_REG_IRQ_STAT);
      chk(d, 32'h0);
      chk(irq, 1'b0);
    end
    $display("test stop modes done");
    complete_run;
  end
endmodule
`default_nettype wire
